// >>> rtl/sce_regs.svh
// Register offsets, field positions, codes and reset values of the socket command block
`ifndef SCE_REGS_SVH
`define SCE_REGS_SVH

// Register indices (byte address = 4 * index)
`define SCE_IDX_MODE 8'h00
`define SCE_IDX_CMD 8'h01
`define SCE_IDX_EVT 8'h02
`define SCE_IDX_STATE 8'h03
`define SCE_IDX_MASK 8'h2C
`define SCE_IDX_DHA_HI 8'h06
`define SCE_IDX_DHA_LO 8'h07
`define SCE_IDX_TX_RD 8'h22
`define SCE_IDX_TX_WR 8'h24
`define SCE_IDX_RX_RD 8'h28

// Command codes
`define SCE_CMD_NONE 8'h00
`define SCE_CMD_OPEN 8'h01
`define SCE_CMD_TEARDOWN 8'h08
`define SCE_CMD_CLOSE 8'h10
`define SCE_CMD_SEND 8'h20
`define SCE_CMD_HW_SEND 8'h21
`define SCE_CMD_KEEPALIVE 8'h22
`define SCE_CMD_RX_CONSUME 8'h40

// Socket state codes
`define SCE_ST_RELEASED 8'h00
`define SCE_ST_INIT 8'h13
`define SCE_ST_CONNECTED 8'h17
`define SCE_ST_CLOSE_WAIT 8'h1C
`define SCE_ST_UDP 8'h22
`define SCE_ST_FIN_WAIT 8'h18
`define SCE_ST_LAST_ACK 8'h1D

// Protocol mode field
`define SCE_MODE_TCP 4'h1
`define SCE_MODE_UDP 4'h2

// Event flag bit positions
`define SCE_EVT_UP 0
`define SCE_EVT_PEER_CLOSE 1
`define SCE_EVT_RX_DATA 2
`define SCE_EVT_TIMEOUT 3
`define SCE_EVT_TX_DONE 4
`define SCE_EVT_USED 8'h1F

// Reset values
`define SCE_RST_EVT 8'h00
`define SCE_RST_MASK 8'hFF
`define SCE_RST_DHA 48'hFFFFFFFFFFFF

`endif

// >>> rtl/sce_pkg.sv
// Types shared by the socket command and event block
package sce_pkg;

  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] dat;
    logic we;
    logic [3:0] sel;
    logic cyc;
    logic stb;
  } sce_wb_req_type;

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
  } sce_wb_rsp_type;

  // Outcomes reported by the packet engines, one-cycle pulses
  typedef struct packed {
    logic established;
    logic fin_rx;
    logic finack_rx;
    logic rst_rx;
    logic data_rx;
    logic arp_timeout;
    logic tcp_timeout;
    logic send_done;
  } sce_net_evt_type;

  // Job requests toward the packet engines
  typedef struct packed {
    logic send_fin;
    logic send_data;
    logic use_arp;
    logic send_keepalive;
    logic rx_consume;
  } sce_net_req_type;

  typedef enum logic [1:0] {
    SCE_OP_IDLE,
    SCE_OP_TEARDOWN,
    SCE_OP_KEEPALIVE,
    SCE_OP_SEND
  } sce_op_type;

endpackage : sce_pkg

// >>> rtl/sce_event_flags.sv
// Sticky socket event flags with mask gating and write-one-to-clear
`timescale 1ns/1ps
`include "sce_regs.svh"

module sce_event_flags #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Events and controls
  input wire logic [WIDTH-1:0] i_event,
  input wire logic [WIDTH-1:0] i_mask,
  input wire logic [WIDTH-1:0] i_clear,
  // Flags
  output logic [WIDTH-1:0] o_flags
);

  logic [WIDTH-1:0] next_flags;
  logic [WIDTH-1:0] used;

  assign used = WIDTH'(`SCE_EVT_USED);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      // Set beats clear so an event in the clearing cycle survives
      assign next_flags[g] = used[g] & ((i_event[g] & i_mask[g])
        | (o_flags[g] & ~i_clear[g]));
    end
  endgenerate

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_flags <= WIDTH'(`SCE_RST_EVT);
    else
      o_flags <= next_flags;
  end

endmodule : sce_event_flags

// >>> rtl/sce_wb_slave.sv
// Classic Wishbone slave front end: one-cycle ack, write strobe and registered read data
`timescale 1ns/1ps

module sce_wb_slave (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Bus
  input sce_pkg::sce_wb_req_type i_wb,
  output sce_pkg::sce_wb_rsp_type o_wb,
  // Register side
  input wire logic [31:0] i_rdata,
  output logic o_wr_stb,
  output logic [7:0] o_idx,
  output logic [31:0] o_wdata,
  output logic [3:0] o_sel
);
  import sce_pkg::*;

  logic ack;
  logic take;

  // Ack one cycle after request; dropped the cycle after
  assign take = i_wb.cyc & i_wb.stb & ~ack;
  assign o_wr_stb = take & i_wb.we;
  assign o_idx = i_wb.adr[7:0] >> 2;
  assign o_wdata = i_wb.dat;
  assign o_sel = i_wb.sel;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ack <= 1'b0;
      o_wb <= '0;
    end
    else
    begin
      ack <= take;
      o_wb.ack <= take;
      o_wb.dat <= take ? i_rdata : 32'h0000_0000;
    end
  end

endmodule : sce_wb_slave

// >>> rtl/sce_socket_cmd.sv
// Socket command interpreter, state tracking and register file
//
// Notes on behaviour
// - Failed connect by ARP timeout, TCP timeout or peer reset closes the socket.
// - Teardown command 0x08 is TCP only; active close sends FIN to peer.
// - Passive close: after peer FIN, teardown answers with own FIN.
// - Teardown finishing with peer FIN/ACK moves socket to closed.
// - Failed teardown raises timeout flag bit 3, then closes the socket.
// - Command 0x10 closes the socket at once without FIN exchange.
// - Peer reset packet during communication forces the socket closed.
// - Command 0x20 sends all transmit buffer data between read and write pointers.
// - Command 0x20 first resolves the destination hardware address by ARP.
// - Command 0x21, UDP only, sends without ARP using host-written hardware address.
// - Command 0x22, TCP only, sends a one-byte keep-alive packet.
// - Keep-alive with no answer before timeout ends connection and raises timeout.
// - Command 0x40 finishes receive processing using the receive read pointer.
// - An event sets its flag only when the matching mask bit is one.
// - Writing one to a flag bit clears it.
// - Bit 4 sets when a send completes; bits 7 to 5 are reserved.
// - Bit 3 sets on ARP timeout or TCP timeout.
// - Bit 2 sets each time data arrives from the peer.
// - Bit 1 sets when FIN or FIN/ACK arrives from the peer.
// - Bit 0 sets once when the connection becomes established.
// - Command register reads back 0x00 right after a command is accepted.
// - Closed state reads as code 0x00.
`timescale 1ns/1ps
`include "sce_regs.svh"

module sce_socket_cmd #(
  parameter int PTR_W = 16
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Wishbone
  input sce_pkg::sce_wb_req_type i_wb,
  output sce_pkg::sce_wb_rsp_type o_wb,
  // Packet engine events
  input sce_pkg::sce_net_evt_type i_net,
  // Packet engine requests: one-cycle job pulses, then pointers and address
  output sce_pkg::sce_net_req_type o_req,
  output logic [47:0] o_dest_hw_addr,
  output logic [PTR_W-1:0] o_tx_from,
  output logic [PTR_W-1:0] o_tx_to,
  output logic [PTR_W-1:0] o_rx_read_pointer,
  // Socket state
  output logic [7:0] o_socket_state
);
  import sce_pkg::*;

  // ****************************************
  // Register bus
  // ****************************************
  logic wr_stb;
  logic [7:0] idx;
  logic [31:0] wdata;
  logic [3:0] sel;
  logic [31:0] rdata;

  sce_wb_slave u_bus (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_wb(i_wb),
    .o_wb(o_wb),
    .i_rdata(rdata),
    .o_wr_stb(wr_stb),
    .o_idx(idx),
    .o_wdata(wdata),
    .o_sel(sel)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  logic wr_lo;
  assign wr_lo = wr_stb & sel[0];

  logic wr_mode;
  logic wr_cmd;
  logic wr_evt;
  logic wr_mask;
  logic wr_dha_hi;
  logic wr_dha_lo;
  logic wr_tx_rd;
  logic wr_tx_wr;
  logic wr_rx_rd;
  assign wr_mode = wr_lo & hit(idx, `SCE_IDX_MODE);
  assign wr_cmd = wr_lo & hit(idx, `SCE_IDX_CMD);
  assign wr_evt = wr_lo & hit(idx, `SCE_IDX_EVT);
  assign wr_mask = wr_lo & hit(idx, `SCE_IDX_MASK);
  assign wr_dha_hi = wr_stb & hit(idx, `SCE_IDX_DHA_HI);
  assign wr_dha_lo = wr_stb & hit(idx, `SCE_IDX_DHA_LO);
  assign wr_tx_rd = wr_stb & hit(idx, `SCE_IDX_TX_RD);
  assign wr_tx_wr = wr_stb & hit(idx, `SCE_IDX_TX_WR);
  assign wr_rx_rd = wr_stb & hit(idx, `SCE_IDX_RX_RD);

  // ****************************************
  // Software registers
  // ****************************************
  logic [3:0] mode;
  logic [7:0] mask;
  logic [47:0] dha;
  logic [PTR_W-1:0] tx_rd;
  logic [PTR_W-1:0] tx_wr;
  logic [PTR_W-1:0] rx_rd;
  logic [7:0] cmd;

  // Narrow registers need byte lane 0; pointers and address take any lane
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mode <= 4'h0;
      mask <= `SCE_RST_MASK;
      dha <= `SCE_RST_DHA;
      tx_rd <= '0;
      tx_wr <= '0;
      rx_rd <= '0;
    end
    else
    begin
      if (wr_mode)
        mode <= wdata[3:0];
      if (wr_mask)
        mask <= wdata[7:0];
      if (wr_dha_hi)
        dha[47:32] <= wdata[15:0];
      if (wr_dha_lo)
        dha[31:0] <= wdata;
      if (wr_tx_rd)
        tx_rd <= wdata[PTR_W-1:0];
      if (wr_tx_wr)
        tx_wr <= wdata[PTR_W-1:0];
      if (wr_rx_rd)
        rx_rd <= wdata[PTR_W-1:0];
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  logic is_tcp;
  logic is_udp;
  assign is_tcp = (mode == `SCE_MODE_TCP);
  assign is_udp = (mode == `SCE_MODE_UDP);

  logic c_open;
  logic c_tear;
  logic c_close;
  logic c_send;
  logic c_hw_send;
  logic c_keep;
  logic c_rx;
  // Commands for the wrong mode fall through doing nothing
  assign c_open = wr_cmd & (wdata[7:0] == `SCE_CMD_OPEN);
  assign c_tear = wr_cmd & (wdata[7:0] == `SCE_CMD_TEARDOWN) & is_tcp;
  assign c_close = wr_cmd & (wdata[7:0] == `SCE_CMD_CLOSE);
  assign c_send = wr_cmd & (wdata[7:0] == `SCE_CMD_SEND);
  assign c_hw_send = wr_cmd & (wdata[7:0] == `SCE_CMD_HW_SEND) & is_udp;
  assign c_keep = wr_cmd & (wdata[7:0] == `SCE_CMD_KEEPALIVE) & is_tcp;
  assign c_rx = wr_cmd & (wdata[7:0] == `SCE_CMD_RX_CONSUME);

  // ****************************************
  // Socket state machine
  // ****************************************
  logic [7:0] state;
  logic [7:0] next_state;
  sce_op_type op;
  sce_op_type next_op;
  logic up_seen;
  logic timeout_ev;
  logic fin_ev;
  logic conn_ev;
  logic open_st;

  assign timeout_ev = i_net.arp_timeout | i_net.tcp_timeout;
  assign fin_ev = i_net.fin_rx | i_net.finack_rx;
  assign open_st = (state != `SCE_ST_RELEASED) & (state != `SCE_ST_INIT);
  // Established reported only once per connection
  // Listen and connect phases live in the engines; INIT stands for them here
  assign conn_ev = i_net.established & ~up_seen & is_tcp & (state == `SCE_ST_INIT);

  // Send, teardown and keep-alive jobs only reach the engines from an open socket, so a stray command on a
  // closed socket cannot park the machine in a closing state with no FIN sent
  logic go_tear;
  logic go_send;
  logic go_keep;
  assign go_tear = c_tear & open_st;
  assign go_send = (c_send | c_hw_send) & open_st;
  assign go_keep = c_keep & (state == `SCE_ST_CONNECTED);

  // Close, peer reset and TCP-mode timeouts win over every other state and job choice, so a command racing
  // an engine event can never leave the socket half open
  always_comb
  begin
    next_state = state;
    next_op = op;
    if (c_close | i_net.rst_rx | (timeout_ev & is_tcp))
    begin
      next_state = `SCE_ST_RELEASED;
      next_op = SCE_OP_IDLE;
    end
    else if (c_open)
    begin
      next_state = is_tcp ? `SCE_ST_INIT : (is_udp ? `SCE_ST_UDP : state);
    end
    else if (go_tear)
    begin
      next_state = (state == `SCE_ST_CLOSE_WAIT) ? `SCE_ST_LAST_ACK : `SCE_ST_FIN_WAIT;
      next_op = SCE_OP_TEARDOWN;
    end
    else if (i_net.finack_rx & (op == SCE_OP_TEARDOWN))
    begin
      next_state = `SCE_ST_RELEASED;
      next_op = SCE_OP_IDLE;
    end
    else if (conn_ev)
      next_state = `SCE_ST_CONNECTED;
    else if (i_net.fin_rx & (state == `SCE_ST_CONNECTED))
      next_state = `SCE_ST_CLOSE_WAIT;
    else if (go_keep)
      next_op = SCE_OP_KEEPALIVE;
    else if (go_send)
      next_op = SCE_OP_SEND;
    // A failed UDP send ends in an ARP timeout, which also retires the job
    else if ((i_net.send_done | i_net.arp_timeout) & (op != SCE_OP_TEARDOWN))
      next_op = SCE_OP_IDLE;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= `SCE_ST_RELEASED;
      op <= SCE_OP_IDLE;
      up_seen <= 1'b0;
      cmd <= `SCE_CMD_NONE;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      // Any command written is taken at once, so it reads back cleared
      cmd <= `SCE_CMD_NONE;
      if (next_state == `SCE_ST_RELEASED)
        up_seen <= 1'b0;
      else if (conn_ev)
        up_seen <= 1'b1;
    end
  end

  // ****************************************
  // Requests to the packet engines
  // ****************************************
  // One-cycle job pulses; pointers stand until the next job, address follows the register
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_req <= '0;
      o_tx_from <= '0;
      o_tx_to <= '0;
      o_rx_read_pointer <= '0;
      o_dest_hw_addr <= `SCE_RST_DHA;
      o_socket_state <= `SCE_ST_RELEASED;
    end
    else
    begin
      // Active close and passive reply both send FIN
      o_req.send_fin <= go_tear;
      o_req.send_data <= go_send;
      o_req.use_arp <= c_send & open_st;
      o_req.send_keepalive <= go_keep;
      o_req.rx_consume <= c_rx;
      if (go_send)
      begin
        o_tx_from <= tx_rd;
        o_tx_to <= tx_wr;
      end
      if (c_rx)
        o_rx_read_pointer <= rx_rd;
      o_dest_hw_addr <= dha;
      o_socket_state <= next_state;
    end
  end

  // ****************************************
  // Event flags
  // ****************************************
  logic [7:0] ev_in;
  logic [7:0] ev_flags;
  logic tx_done_ev;
  logic [7:0] ev_clear;
  // Only a pending send may report completion; probes and FINs do not
  assign tx_done_ev = i_net.send_done & (op == SCE_OP_SEND);
  assign ev_clear = wr_evt ? wdata[7:0] : 8'h00;
  assign ev_in = {3'b000,
                  tx_done_ev,
                  timeout_ev,
                  i_net.data_rx,
                  fin_ev,
                  conn_ev};

  sce_event_flags #(
    .WIDTH(8)
  ) u_flags (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_event(ev_in),
    .i_mask(mask),
    .i_clear(ev_clear),
    .o_flags(ev_flags)
  );

  // ****************************************
  // Read mux
  // ****************************************
  // Unmapped indices read as zero; their writes are dropped but still acked
  always_comb
  begin
    rdata = 32'h0000_0000;
    if (hit(idx, `SCE_IDX_MODE))
      rdata = {28'h0000000, mode};
    else if (hit(idx, `SCE_IDX_CMD))
      rdata = {24'h000000, cmd};
    else if (hit(idx, `SCE_IDX_EVT))
      rdata = {24'h000000, ev_flags};
    else if (hit(idx, `SCE_IDX_STATE))
      rdata = {24'h000000, state};
    else if (hit(idx, `SCE_IDX_MASK))
      rdata = {24'h000000, mask};
    else if (hit(idx, `SCE_IDX_DHA_HI))
      rdata = {16'h0000, dha[47:32]};
    else if (hit(idx, `SCE_IDX_DHA_LO))
      rdata = dha[31:0];
    else if (hit(idx, `SCE_IDX_TX_RD))
      rdata = 32'(tx_rd);
    else if (hit(idx, `SCE_IDX_TX_WR))
      rdata = 32'(tx_wr);
    else if (hit(idx, `SCE_IDX_RX_RD))
      rdata = 32'(rx_rd);
  end

endmodule : sce_socket_cmd

// >>> bench/sce_socket_cmd_asserts.sv
// Port checks of the socket command block
`timescale 1ns/1ps
module sce_socket_cmd_asserts
  import sce_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Watched ports
  input sce_pkg::sce_wb_req_type i_wb,
  input sce_pkg::sce_wb_rsp_type o_wb,
  input sce_pkg::sce_net_evt_type i_net,
  input sce_pkg::sce_net_req_type o_req,
  input wire logic [7:0] o_socket_state
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Commands racing an engine event are left out: priority is open
  wire logic take = i_wb.cyc && i_wb.stb && !o_wb.ack;
  wire logic cmd_any = take && i_wb.we && i_wb.sel[0] && (i_wb.adr == 8'h04);
  wire logic cmd_wr = cmd_any && (i_net == '0);
  wire logic [7:0] cmd = i_wb.dat[7:0];
  wire logic [7:0] st = o_socket_state;
  chk_ack_next: assert property (take |=> o_wb.ack) else $error("ack missing");
  chk_ack_drop: assert property (o_wb.ack |=> !o_wb.ack) else $error("ack too long");
  chk_cmd_clear: assert property (take && !i_wb.we && i_wb.adr == 8'h04
    |=> o_wb.dat[7:0] == 8'h00) else $error("command not cleared");
  chk_close_now: assert property (cmd_wr && cmd == 8'h10
    |=> st == 8'h00 && !o_req.send_fin) else $error("close not immediate");
  chk_fin_active: assert property (cmd_wr && cmd == 8'h08 && st == 8'h17
    |=> o_req.send_fin && st == 8'h18) else $error("active close wrong");
  chk_fin_passive: assert property (cmd_wr && cmd == 8'h08 && st == 8'h1C
    |=> o_req.send_fin && st == 8'h1D) else $error("passive close wrong");
  chk_peer_reset: assert property (i_net.rst_rx |=> st == 8'h00)
    else $error("reset packet ignored");
  chk_teardown_end: assert property ((st == 8'h18 || st == 8'h1D) && !cmd_any
    && (i_net.finack_rx || i_net.tcp_timeout) |=> st == 8'h00) else $error("teardown stuck");
  chk_send_arp: assert property (cmd_wr && cmd == 8'h20 && st == 8'h17
    |=> o_req.send_data && o_req.use_arp) else $error("send request wrong");
  chk_hw_send: assert property (cmd_wr && cmd == 8'h21 && st == 8'h22
    |=> o_req.send_data && !o_req.use_arp) else $error("explicit send wrong");
  chk_keep_probe: assert property (cmd_wr && cmd == 8'h22 && st == 8'h17
    |=> o_req.send_keepalive) else $error("probe missing");
  chk_rx_done: assert property (cmd_wr && cmd == 8'h40 && st == 8'h17
    |=> o_req.rx_consume) else $error("consume missing");
  chk_mode_guard: assert property (cmd_wr && (cmd == 8'h08 || cmd == 8'h22) && st == 8'h22
    |=> $stable(st) && !o_req.send_fin && !o_req.send_keepalive) else $error("mode ignored");
  cov_teardown: cover property (st == 8'h18 ##1 st == 8'h00);
  cov_hw_send: cover property (o_req.send_data && !o_req.use_arp);
  cov_reset_pkt: cover property (i_net.rst_rx && st == 8'h17);
endmodule : sce_socket_cmd_asserts

bind sce_socket_cmd sce_socket_cmd_asserts u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_wb(i_wb), .o_wb(o_wb), .i_net(i_net), .o_req(o_req), .o_socket_state(o_socket_state));

// >>> bench/sce_engine_model.sv
// Packet engine stand-in answering the block's job requests
`timescale 1ns/1ps
module sce_engine_model
  import sce_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Jobs and answer style
  input sce_pkg::sce_net_req_type i_req,
  input wire logic i_fail,
  input wire logic i_slow,
  // Outcomes
  output sce_pkg::sce_net_evt_type o_evt,
  output logic [7:0] o_fin_count
);
  logic [3:0] wait_cnt;
  logic [1:0] job;
  // A failing peer stays silent, so the job ends in a timeout
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_evt <= '0;
      o_fin_count <= 8'h00;
      wait_cnt <= 4'h0;
      job <= 2'h0;
    end
    else
    begin
      o_evt <= '0;
      if (i_req.send_fin)
        o_fin_count <= o_fin_count + 8'h01;
      if (i_req.send_fin || i_req.send_data || i_req.send_keepalive)
      begin
        job <= i_req.send_fin ? 2'h1 : (i_req.send_data ? 2'h2 : 2'h3);
        wait_cnt <= i_slow ? 4'h9 : 4'h2;
      end
      else if (wait_cnt != 4'h0)
      begin
        wait_cnt <= wait_cnt - 4'h1;
        if (wait_cnt == 4'h1)
        begin
          o_evt.finack_rx <= (job == 2'h1) && !i_fail;
          o_evt.send_done <= (job == 2'h2) && !i_fail;
          o_evt.arp_timeout <= (job == 2'h2) && i_fail;
          o_evt.tcp_timeout <= (job != 2'h2) && i_fail;
        end
      end
    end
  end
endmodule : sce_engine_model

// >>> bench/sce_socket_cmd_tb.sv
// Self-checking bench of the socket command block
`timescale 1ns/1ps
module sce_socket_cmd_tb;
  import sce_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic fail = 1'b0;
  logic slow = 1'b0;
  sce_wb_req_type wb = '0;
  sce_wb_rsp_type rsp;
  sce_net_evt_type tb_net = '0;
  sce_net_evt_type eng_net;
  sce_net_evt_type net;
  sce_net_req_type req;
  logic [47:0] hw;
  logic [15:0] tx_from, tx_to, rx_ptr;
  logic [7:0] state, fins;
  logic [31:0] rdat;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  assign net = tb_net | eng_net;
  always #5 i_ref_clk = ~i_ref_clk;
  sce_socket_cmd u_sce_socket_cmd (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_wb(wb),
    .o_wb(rsp), .i_net(net), .o_req(req), .o_dest_hw_addr(hw), .o_tx_from(tx_from),
    .o_tx_to(tx_to), .o_rx_read_pointer(rx_ptr), .o_socket_state(state));
  sce_engine_model u_sce_engine_model (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_req(req), .i_fail(fail), .i_slow(slow), .o_evt(eng_net), .o_fin_count(fins));
  // ***********
  // Bus and checks
  // ***********
  task automatic wb_cyc(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge i_ref_clk);
    wb <= '{adr: a, dat: d, we: w, sel: 4'hF, cyc: 1'b1, stb: 1'b1};
    do @(posedge i_ref_clk); while (rsp.ack !== 1'b1);
    rdat = rsp.dat;
    wb <= '0;
  endtask : wb_cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_cyc(a, 1'b1, d);
  endtask : wr
  task automatic chk_val(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    wb_cyc(a, 1'b0, 32'h0);
    chk_val({16'h0000, rdat}, {16'h0000, exp});
  endtask : chk_reg
  task automatic pulse(input sce_net_evt_type e);
    @(posedge i_ref_clk);
    tb_net <= e;
    @(posedge i_ref_clk);
    tb_net <= '0;
    @(posedge i_ref_clk);
  endtask : pulse
  task automatic wait_eng();
    for (int n = 0; n < 40 && eng_net === '0; n++)
      @(posedge i_ref_clk);
    @(posedge i_ref_clk);
  endtask : wait_eng
  task automatic wait_state(input logic [7:0] exp);
    for (int n = 0; n < 40 && state !== exp; n++)
      @(posedge i_ref_clk);
    chk_val(state, exp);
  endtask : wait_state
  task automatic tcp_up();
    wr(8'h04, 32'h10);
    wr(8'h08, 32'hFF);
    wr(8'h00, 32'h01);
    wr(8'h04, 32'h01);
    pulse('{established: 1'b1, default: 1'b0});
    chk_reg(8'h0C, 32'h17);
    chk_reg(8'h08, 32'h01);
    wr(8'h08, 32'hFF);
    chk_reg(8'h08, 32'h00);
  endtask : tcp_up
  // ***********
  // Scenarios
  // ***********
  task automatic t_reset();
    chk_reg(8'h0C, 32'h00);
    chk_reg(8'h08, 32'h00);
    chk_reg(8'hB0, 32'hFF);
    chk_reg(8'h18, 32'h0000FFFF);
    chk_reg(8'h1C, 32'hFFFFFFFF);
    wr(8'hFC, 32'h5A);
    chk_reg(8'hFC, 32'h00);
  endtask : t_reset
  task automatic t_active(input logic f, input logic s);
    tcp_up();
    fail <= f;
    slow <= s;
    wr(8'h04, 32'h08);
    chk_val(state, 8'h18);
    chk_reg(8'h04, 32'h00);
    wait_state(8'h00);
    chk_reg(8'h08, f ? 32'h08 : 32'h02);
    fail <= 1'b0;
  endtask : t_active
  task automatic t_passive();
    logic [7:0] n;
    tcp_up();
    pulse('{fin_rx: 1'b1, default: 1'b0});
    chk_reg(8'h08, 32'h02);
    n = fins;
    wr(8'h04, 32'h08);
    chk_val(state, 8'h1D);
    wait_state(8'h00);
    chk_val(fins, n + 8'h01);
  endtask : t_passive
  task automatic t_close_rst();
    logic [7:0] n;
    tcp_up();
    n = fins;
    wr(8'h04, 32'h10);
    chk_val(state, 8'h00);
    repeat (4) @(posedge i_ref_clk);
    chk_val(fins, n);
    tcp_up();
    pulse('{rst_rx: 1'b1, default: 1'b0});
    chk_val(state, 8'h00);
  endtask : t_close_rst
  task automatic t_send();
    tcp_up();
    wr(8'h88, 32'h0010);
    wr(8'h90, 32'h0123);
    wr(8'h04, 32'h20);
    wait_eng();
    chk_val(tx_from, 16'h0010);
    chk_val(tx_to, 16'h0123);
    chk_reg(8'h08, 32'h10);
    pulse('{data_rx: 1'b1, default: 1'b0});
    chk_reg(8'h08, 32'h14);
    wr(8'hA0, 32'h0456);
    wr(8'h04, 32'h40);
    chk_val(rx_ptr, 16'h0456);
  endtask : t_send
  task automatic t_udp();
    wr(8'h04, 32'h10);
    wr(8'h08, 32'hFF);
    wr(8'h00, 32'h02);
    wr(8'h04, 32'h01);
    wr(8'h18, 32'h1234);
    wr(8'h1C, 32'h56789ABC);
    wr(8'h04, 32'h21);
    wait_eng();
    chk_val(hw, 48'h123456789ABC);
    chk_reg(8'h08, 32'h10);
    wr(8'h04, 32'h22);
    wr(8'h04, 32'h08);
    chk_val(state, 8'h22);
  endtask : t_udp
  task automatic t_keep();
    tcp_up();
    fail <= 1'b1;
    wr(8'h04, 32'h22);
    wait_state(8'h00);
    chk_reg(8'h08, 32'h08);
    fail <= 1'b0;
  endtask : t_keep
  task automatic t_mask();
    tcp_up();
    wr(8'hB0, 32'hFB);
    pulse('{data_rx: 1'b1, default: 1'b0});
    chk_reg(8'h08, 32'h00);
    wr(8'hB0, 32'hFF);
    pulse('{arp_timeout: 1'b1, default: 1'b0});
    chk_reg(8'h08, 32'h08);
    wr(8'h04, 32'h01);
    chk_val(state, 8'h13);
    pulse('{tcp_timeout: 1'b1, default: 1'b0});
    chk_val(state, 8'h00);
  endtask : t_mask
  task automatic end_of_test();
    $display("err_count=%0d tests_run=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // Whole run needs a few hundred cycles
  always @(posedge i_ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (3) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_active(1'b0, 1'b0);
    t_active(1'b1, 1'b1);
    t_passive();
    t_close_rst();
    t_send();
    t_udp();
    t_keep();
    t_mask();
    end_of_test();
  end
endmodule : sce_socket_cmd_tb
